// [rtl/recorder_pkg.sv]
// shared constants of the disturbance recorder control block
package recorder_pkg;

  // ************************************************************
  // register map (byte addresses, avalon word per register)
  // ************************************************************
  localparam logic [5:0] OFS_CTRL       = 6'h00;
  localparam logic [5:0] OFS_PRETRIG    = 6'h04;
  localparam logic [5:0] OFS_STATUS     = 6'h08;
  localparam logic [5:0] OFS_LAST_START = 6'h0C;
  localparam logic [5:0] OFS_IRQ_STATUS = 6'h10;
  localparam logic [5:0] OFS_IRQ_CLEAR  = 6'h14;
  localparam logic [5:0] OFS_IRQ_ENABLE = 6'h18;
  localparam logic [5:0] OFS_MEM_DATA   = 6'h1C;
  localparam logic [5:0] OFS_MEM_ADDR   = 6'h20;

  // ************************************************************
  // control fields
  // ************************************************************
  localparam int CTRL_SLOT_LSB  = 0;  // 2 bits: 1=2, 2=4, 3=8 slots
  localparam int CTRL_FREQ60    = 2;
  localparam int CTRL_TRIG_LSB  = 3;  // 2 bits, trig_mode_e
  localparam int CTRL_INPUT_LSB = 5;  // 2 bits, input_mode_e
  localparam logic [1:0] SLOT_CODE_RST = 2'h1;
  localparam logic [1:0] SLOT_CODE_MIN = 2'h1;

  // status fields
  localparam int ST_RECORDING = 0;
  localparam int ST_TEST      = 1;
  localparam int ST_SLOT_LSB  = 2;  // 3 bits
  localparam int ST_COUNT_LSB = 5;  // 4 bits

  // interrupt bits
  localparam int IRQ_TRIG = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_W    = 2;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int REC_SECONDS_50HZ = 16;
  localparam int MAINS_50HZ       = 50;
  localparam int REC_PERIODS      = REC_SECONDS_50HZ * MAINS_50HZ;  // same 800 periods at 60 Hz
  localparam int PRE_UNIT_MS      = 10;
  localparam int PRE_MIN_MS       = 50;
  localparam int PRE_MAX_MS       = 8000;
  localparam logic [9:0] PRE_MIN_UNITS = 10'(PRE_MIN_MS / PRE_UNIT_MS);
  localparam logic [9:0] PRE_MAX_UNITS = 10'(PRE_MAX_MS / PRE_UNIT_MS);
  localparam logic [31:0] TENTHS_50HZ  = 32'h5;  // mains periods per 100 ms
  localparam logic [31:0] TENTHS_60HZ  = 32'h6;
  localparam logic [31:0] TENTHS_DIV   = 32'hA;

  typedef enum logic [1:0] {TRIG_PICKUP, TRIG_TRIP, TRIG_AFTER_PICKUP, TRIG_TEST} trig_mode_e;
  typedef enum logic [1:0] {IN_NORMAL, IN_BLOCK_TRIG, IN_RESET_TRIG, IN_SET2_PLUS} input_mode_e;

endpackage : recorder_pkg

// [rtl/record_mem.sv]
// recording memory: one write port, one registered read port
`timescale 1ns/10ps
module record_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 12800,
  parameter int AW    = 14
) (
  // clock
  input  wire logic             core_clk_i,
  // write side
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // read side
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    rd_data_o <= mem_q[rd_addr_i];
  end

endmodule : record_mem

// [rtl/disturbance_recorder_control.sv]
// disturbance recorder control: slot ring, triggers, pre-trigger, avalon registers
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
// What this block does
// - memory holds 800 mains periods: 16 s at 50 Hz, 13.33 s at 60 Hz
// - software picks 2, 4 or 8 slots; slot length follows from it
// - at 50 Hz slots last 8 s, 4 s or 2 s
// - at 60 Hz slots last 6.66 s, 3.33 s or 1.66 s
// - new trigger overwrites one slot, keeping one fewer record than slots
// - pickup mode: record starts when any element picks up
// - trip mode: record starts when a trip is issued
// - after-pickup mode: record starts when the last pickup drops out
// - test mode: both keys together start a record, test shown meanwhile
// - pre-trigger interval settable from 0.05 s to 8 s
// - record holds pre-trigger data then data after the trigger
// - block input as trigger starts a record, indicator lit while recording
// - reset input as trigger starts a record and no longer resets
module disturbance_recorder_control
  import recorder_pkg::*;
#(
  parameter int N_ELEM = 4,
  parameter int WIDTH  = 16,
  parameter int SPP    = 16,
  parameter int DEPTH  = recorder_pkg::REC_PERIODS * SPP,
  parameter int AW     = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // avalon-mm slave
  input  wire logic [5:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // sample stream, one strobe per sample, SPP per mains period
  input  wire logic              sample_valid_i,
  input  wire logic [WIDTH-1:0]  sample_data_i,
  // protection elements and keys
  input  wire logic [N_ELEM-1:0] pickup_i,
  input  wire logic              trip_i,
  input  wire logic              key_inc_i,
  input  wire logic              key_dec_i,
  // external inputs
  input  wire logic              block_input_i,
  input  wire logic              reset_input_i,
  // outputs
  output logic                   block_out_o,
  output logic                   reset_out_o,
  output logic                   param_set2_o,
  output logic                   recording_indicator_o,
  output logic                   test_display_o,
  output logic                   irq_o
);
  import recorder_pkg::*;

  typedef enum logic {ARM, POST} rec_state_e;

  // ************************************************************
  // registers
  // ************************************************************
  logic [1:0]         slot_code_q;
  logic               freq60_q;
  trig_mode_e         trig_mode_q;
  input_mode_e        input_mode_q;
  logic [9:0]         pre_units_q;
  logic [IRQ_W-1:0]   irq_status_q, irq_en_q;
  logic [AW-1:0]      mem_addr_q, last_start_q;
  logic               ack_q, dly_q;
  rec_state_e         state_q;
  logic [2:0]         slot_q;
  logic [3:0]         count_q;
  logic [AW-1:0]      wofs_q, fill_q, post_left_q;
  logic               test_rec_q;
  logic               pk_q, trip_q, keys_q, blk_q, rstin_q;
  logic [WIDTH-1:0]   mem_rdata;

  // ************************************************************
  // bus handshake
  // ************************************************************
  logic req, wr_hit, rd_hit, ctrl_wr, is_mem;
  assign req     = avs_read_i | avs_write_i;
  // only a memory read needs the extra cycle; a write there is ignored at once
  assign is_mem  = avs_read_i && avs_address_i == OFS_MEM_DATA;
  assign wr_hit  = avs_write_i & ack_q;
  assign rd_hit  = avs_read_i & ack_q;
  assign ctrl_wr = wr_hit && avs_address_i == OFS_CTRL;

  // memory reads wait one more cycle for the registered ram output
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dly_q <= 1'b0;
    end else begin
      dly_q <= req & ~ack_q & ~dly_q;
      ack_q <= req & ~ack_q & (~is_mem | dly_q);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(req & ~ack_q & (~is_mem | dly_q));
    end
  end

  // ************************************************************
  // configuration
  // ************************************************************
  logic [9:0] pre_wr;
  assign pre_wr = avs_writedata_i[9:0];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_code_q  <= SLOT_CODE_RST;
      freq60_q     <= 1'b0;
      trig_mode_q  <= TRIG_PICKUP;
      input_mode_q <= IN_NORMAL;
    end else if (ctrl_wr) begin
      // code 0 is not a slot count; fall back to two slots
      slot_code_q  <= (avs_writedata_i[CTRL_SLOT_LSB+:2] < SLOT_CODE_MIN) ? SLOT_CODE_MIN
                      : avs_writedata_i[CTRL_SLOT_LSB+:2];
      freq60_q     <= avs_writedata_i[CTRL_FREQ60];
      trig_mode_q  <= trig_mode_e'(avs_writedata_i[CTRL_TRIG_LSB+:2]);
      input_mode_q <= input_mode_e'(avs_writedata_i[CTRL_INPUT_LSB+:2]);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_units_q <= PRE_MIN_UNITS;
    end else if (wr_hit && avs_address_i == OFS_PRETRIG) begin
      pre_units_q <= (pre_wr < PRE_MIN_UNITS) ? PRE_MIN_UNITS
                     : (pre_wr > PRE_MAX_UNITS) ? PRE_MAX_UNITS : pre_wr;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en_q <= '0;
    end else if (wr_hit && avs_address_i == OFS_IRQ_ENABLE) begin
      irq_en_q <= avs_writedata_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_addr_q <= '0;
    end else if (wr_hit && avs_address_i == OFS_MEM_ADDR) begin
      mem_addr_q <= avs_writedata_i[AW-1:0];
    end else if (rd_hit && is_mem) begin
      mem_addr_q <= (mem_addr_q == AW'(DEPTH - 1)) ? '0 : mem_addr_q + 1'b1;
    end
  end

  // ************************************************************
  // trigger sources
  // ************************************************************
  logic pk_any, keys_both, trig_blk, trig_rst, trig_mode_hit, trig;
  assign pk_any    = |pickup_i;
  assign keys_both = key_inc_i & key_dec_i;
  assign trig_blk  = (input_mode_q == IN_BLOCK_TRIG) & block_input_i & ~blk_q;
  assign trig_rst  = (input_mode_q == IN_RESET_TRIG || input_mode_q == IN_SET2_PLUS)
                     & reset_input_i & ~rstin_q;

  always_comb begin
    case (trig_mode_q)
      TRIG_PICKUP:       trig_mode_hit = pk_any & ~pk_q;
      TRIG_TRIP:         trig_mode_hit = trip_i & ~trip_q;
      TRIG_AFTER_PICKUP: trig_mode_hit = ~pk_any & pk_q;
      TRIG_TEST:         trig_mode_hit = keys_both & ~keys_q;
      default:           trig_mode_hit = 1'b0;
    endcase
  end
  assign trig = trig_mode_hit | trig_blk | trig_rst;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pk_q    <= 1'b0;
      trip_q  <= 1'b0;
      keys_q  <= 1'b0;
      blk_q   <= 1'b0;
      rstin_q <= 1'b0;
    end else begin
      pk_q    <= pk_any;
      trip_q  <= trip_i;
      keys_q  <= keys_both;
      blk_q   <= block_input_i;
      rstin_q <= reset_input_i;
    end
  end

  // ************************************************************
  // slot geometry and pre-trigger length
  // ************************************************************
  logic [AW-1:0]   slot_len, pre_clip, avail, wofs_n, fill_n, start_ofs;
  logic [AW+2:0]   base_full;
  logic [AW-1:0]   wr_addr;
  logic [31:0]     pre_full;
  logic [3:0]      slots;

  assign slots     = 4'h1 << slot_code_q;
  // fixed 800 periods split evenly: 8/4/2 s at 50 Hz, 6.66/3.33/1.66 s at 60 Hz
  assign slot_len  = AW'(DEPTH >> slot_code_q);
  assign base_full = {3'h0, slot_len} * {{AW{1'b0}}, slot_q};
  assign wr_addr   = base_full[AW-1:0] + wofs_q;
  assign pre_full  = (32'(pre_units_q) * 32'(SPP) * (freq60_q ? TENTHS_60HZ : TENTHS_50HZ)) / TENTHS_DIV;
  // pre-trigger longer than a slot is cut so at least one post sample fits
  assign pre_clip  = (pre_full >= 32'(slot_len)) ? slot_len - 1'b1 : pre_full[AW-1:0];
  assign wofs_n    = !sample_valid_i ? wofs_q : (wofs_q == slot_len - 1'b1) ? '0 : wofs_q + 1'b1;
  assign fill_n    = (sample_valid_i && fill_q != slot_len) ? fill_q + 1'b1 : fill_q;
  assign avail     = (fill_n < pre_clip) ? fill_n : pre_clip;
  assign start_ofs = (wofs_n >= avail) ? wofs_n - avail : wofs_n + slot_len - avail;

  // ************************************************************
  // capture sequencer
  // ************************************************************
  logic done;
  assign done = (state_q == POST) & sample_valid_i & (post_left_q == {{(AW-1){1'b0}}, 1'b1});

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q      <= ARM;
      slot_q       <= '0;
      count_q      <= '0;
      wofs_q       <= '0;
      fill_q       <= '0;
      post_left_q  <= '0;
      last_start_q <= '0;
      test_rec_q   <= 1'b0;
    end else if (ctrl_wr) begin
      // new geometry invalidates every stored record
      state_q    <= ARM;
      slot_q     <= '0;
      count_q    <= '0;
      wofs_q     <= '0;
      fill_q     <= '0;
      test_rec_q <= 1'b0;
    end else begin
      case (state_q)
        ARM: begin
          wofs_q <= wofs_n;
          fill_q <= fill_n;
          if (trig) begin
            state_q      <= POST;
            post_left_q  <= slot_len - avail;
            last_start_q <= base_full[AW-1:0] + start_ofs;
            test_rec_q   <= trig_mode_q == TRIG_TEST && trig_mode_hit;
          end
        end
        POST: begin
          wofs_q <= wofs_n;
          if (sample_valid_i) begin
            post_left_q <= post_left_q - 1'b1;
          end
          if (done) begin
            // oldest slot becomes the capture slot; slots-1 records survive
            state_q    <= ARM;
            slot_q     <= (4'(slot_q) == slots - 1'b1) ? '0 : slot_q + 1'b1;
            count_q    <= (count_q == slots - 1'b1) ? count_q : count_q + 1'b1;
            wofs_q     <= '0;
            fill_q     <= '0;
            test_rec_q <= 1'b0;
          end
        end
        default: state_q <= ARM;
      endcase
    end
  end

  record_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .core_clk_i (core_clk_i),
    .wr_en_i    (sample_valid_i),
    .wr_addr_i  (wr_addr),
    .wr_data_i  (sample_data_i),
    .rd_addr_i  (mem_addr_q),
    .rd_data_o  (mem_rdata)
  );

  // ************************************************************
  // interrupts: set wins over clear
  // ************************************************************
  logic [IRQ_W-1:0] irq_set, irq_clr;
  assign irq_set = {done & ~ctrl_wr, trig & (state_q == ARM) & ~ctrl_wr};
  assign irq_clr = (wr_hit && avs_address_i == OFS_IRQ_CLEAR) ? avs_writedata_i[IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_q <= '0;
      irq_o        <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
      irq_o        <= |(((irq_status_q & ~irq_clr) | irq_set) & irq_en_q);
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      OFS_CTRL:       rd_mux = {25'h0, input_mode_q, trig_mode_q, freq60_q, slot_code_q};
      OFS_PRETRIG:    rd_mux = {22'h0, pre_units_q};
      OFS_STATUS:     rd_mux = {23'h0, count_q, slot_q, test_rec_q, state_q == POST};
      OFS_LAST_START: rd_mux = 32'(last_start_q);
      OFS_IRQ_STATUS: rd_mux = 32'(irq_status_q);
      OFS_IRQ_ENABLE: rd_mux = 32'(irq_en_q);
      OFS_MEM_DATA:   rd_mux = 32'(mem_rdata);
      OFS_MEM_ADDR:   rd_mux = 32'(mem_addr_q);
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_q & (~is_mem | dly_q)) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // ************************************************************
  // indicators and external input routing
  // ************************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      recording_indicator_o <= 1'b0;
      test_display_o        <= 1'b0;
      block_out_o           <= 1'b0;
      reset_out_o           <= 1'b0;
      param_set2_o          <= 1'b0;
    end else begin
      recording_indicator_o <= state_q == POST;
      test_display_o        <= test_rec_q & (state_q == POST);
      block_out_o           <= (input_mode_q == IN_NORMAL || input_mode_q == IN_RESET_TRIG) & block_input_i;
      reset_out_o           <= (input_mode_q == IN_NORMAL || input_mode_q == IN_BLOCK_TRIG)
                               & reset_input_i;
      param_set2_o          <= (input_mode_q == IN_SET2_PLUS) & block_input_i;
    end
  end

endmodule : disturbance_recorder_control

// [tb/sample_source.sv]
// sample stream source standing in for the relay's measuring front end
`timescale 1ns/10ps
module sample_source (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // control
  input  wire logic        stall_i,
  // stream
  output logic             sample_valid_o,
  output logic      [15:0] sample_data_o
);
  logic [15:0] cnt_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sample_valid_o <= 1'b0;
      cnt_q          <= 16'h0000;
    end else if (stall_i) begin
      sample_valid_o <= 1'b0;
    end else begin
      sample_valid_o <= 1'b1;
      cnt_q          <= cnt_q + 16'h0001;
    end
  end
  // idle data shows the inverse so a stale word is never taken as fresh
  assign sample_data_o = sample_valid_o ? cnt_q : ~cnt_q;
endmodule : sample_source

// [tb/recorder_properties.sv]
// port-level assertions for the recorder control block
`timescale 1ns/10ps
module recorder_properties
  import recorder_pkg::*;
#(
  parameter int SPP = 16
) (
  // clock and reset
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  // bus and stream
  input wire logic [5:0] avs_address_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  input wire logic       sample_valid_i,
  // inputs and indicators
  input wire logic       block_input_i,
  input wire logic       reset_input_i,
  input wire logic       block_out_o,
  input wire logic       reset_out_o,
  input wire logic       param_set2_o,
  input wire logic       recording_indicator_o,
  input wire logic       test_display_o
);
  localparam int SLOT_MAX = REC_PERIODS * SPP / 2;
  int rec_cnt_q;
  // counts post samples; a record may never outgrow the largest slot
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) rec_cnt_q <= 0;
    else if (!recording_indicator_o) rec_cnt_q <= 0;
    else if (sample_valid_i) rec_cnt_q <= rec_cnt_q + 1;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req_start;
    (avs_read_i || avs_write_i) && avs_waitrequest_o &&
      (!$past(avs_waitrequest_o) || !$past(avs_read_i || avs_write_i));
  endsequence
  a_reg_answer: assert property (s_req_start ##0 !(avs_read_i && avs_address_i == OFS_MEM_DATA)
    |=> !avs_waitrequest_o) else $error("register access answer late");
  a_mem_answer: assert property (s_req_start ##0 (avs_read_i && avs_address_i == OFS_MEM_DATA)
    |=> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("memory read answer wrong");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_idle_wait: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("waitrequest low without request");
  a_block_route: assert property ((block_out_o || param_set2_o) |-> $past(block_input_i))
    else $error("block output without block input");
  a_reset_route: assert property (reset_out_o |-> $past(reset_input_i))
    else $error("reset output without reset input");
  a_set2_only: assert property (param_set2_o |-> !block_out_o && !reset_out_o)
    else $error("set2 mode routes input twice");
  a_test_shown: assert property (test_display_o |-> recording_indicator_o)
    else $error("test shown outside recording");
  a_record_len: assert property (rec_cnt_q <= SLOT_MAX)
    else $error("record longer than a slot");
endmodule : recorder_properties

bind disturbance_recorder_control recorder_properties #(.SPP(SPP)) recorder_properties_inst (
  .core_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .sample_valid_i,
  .block_input_i, .reset_input_i, .block_out_o, .reset_out_o, .param_set2_o, .recording_indicator_o,
  .test_display_o);

// [tb/tb.sv]
// self-checking bench for the recorder control block
`timescale 1ns/10ps
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %0h want %0h", $time, g, e); end end
module tb;
  import recorder_pkg::*;
  localparam int SPP = 2;
  localparam int TRG_T [7] = '{0, 1, 2, 3, 1, 1, 1};
  localparam int INM_T [7] = '{0, 0, 0, 0, 1, 2, 3};
  localparam int SRC_T [7] = '{0, 1, 2, 3, 4, 5, 5};
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [5:0]  avs_address_i = 6'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        sample_valid_i;
  logic [15:0] sample_data_i;
  logic [3:0]  pickup_i = 4'h0;
  logic        trip_i = 1'b0;
  logic        key_inc_i = 1'b0;
  logic        key_dec_i = 1'b0;
  logic        block_input_i = 1'b0;
  logic        reset_input_i = 1'b0;
  logic        stall_i = 1'b0;
  logic        block_out_o, reset_out_o, param_set2_o, recording_indicator_o, test_display_o, irq_o;
  logic [31:0] q;
  logic [15:0] tv;
  int          bad_count, n_tests, k, n, p, units, code, slots, src, inm;

  disturbance_recorder_control #(.SPP(SPP)) disturbance_recorder_control_inst (.core_clk_i, .rst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .sample_valid_i, .sample_data_i, .pickup_i, .trip_i, .key_inc_i, .key_dec_i, .block_input_i,
    .reset_input_i, .block_out_o, .reset_out_o, .param_set2_o, .recording_indicator_o, .test_display_o,
    .irq_o);
  sample_source sample_source_inst (.core_clk_i, .rst_i, .stall_i, .sample_valid_o(sample_valid_i),
    .sample_data_o(sample_data_i));

  always #12.5 core_clk_i = ~core_clk_i;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic int exp_pre(input int u, input int f60);
    return u * SPP * (f60 ? 6 : 5) / 10;
  endfunction : exp_pre

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    // no own limit: only the watchdog ends a wait that never ends
    do begin
      @(posedge core_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic set_src(input logic v);
    pickup_i <= (v && (src == 0 || src == 2)) ? 4'h1 << ($urandom % 4) : 4'h0;
    trip_i <= v && src == 1;
    key_inc_i <= v && src == 3;
    key_dec_i <= v && src == 3;
    block_input_i <= v && src >= 4;
    reset_input_i <= v && src == 5;
  endtask : set_src

  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    k = $urandom(22396);
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHECK(q, 32'h00000001)
    bus(1'b0, OFS_PRETRIG, 32'h0);
    `CHECK(q, 32'h00000005)
    bus(1'b1, 6'h3C, 32'hFFFFFFFF);
    bus(1'b0, 6'h3C, 32'h0);
    `CHECK(q, 32'h00000000)
    bus(1'b1, OFS_PRETRIG, 32'h0);
    bus(1'b0, OFS_PRETRIG, 32'h0);
    `CHECK(q, 32'h00000005)
    bus(1'b1, OFS_PRETRIG, 32'h3FF);
    bus(1'b0, OFS_PRETRIG, 32'h0);
    `CHECK(q, 32'h00000320)
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHECK(q, 32'h00000001)
    @(posedge core_clk_i);
    block_input_i <= 1'b1;
    reset_input_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    `CHECK({block_out_o, reset_out_o, param_set2_o}, 3'h6)
    block_input_i <= 1'b0;
    reset_input_i <= 1'b0;
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      code = 1 + i % 3;
      slots = 1 << code;
      src = SRC_T[i];
      inm = INM_T[i];
      units = 5 + $urandom % 16;
      p = exp_pre(units, i % 2);
      bus(1'b1, OFS_PRETRIG, 32'(units));
      bus(1'b1, OFS_IRQ_ENABLE, (i == 4) ? 32'h0 : 32'h3);
      bus(1'b1, OFS_CTRL, 32'((inm << 5) | (TRG_T[i] << 3) | ((i % 2) << 2) | code));
      for (int r = 0; r < 2; r++) begin
        // stalls only while filling; the record is timed on a gapless stream
        repeat (60) @(posedge core_clk_i) stall_i <= ($urandom % 4) == 0;
        @(posedge core_clk_i);
        stall_i <= 1'b0;
        @(posedge core_clk_i);
        if (src == 2) begin
          set_src(1'b1);
          repeat (3) @(posedge core_clk_i);
        end
        set_src(src != 2);
        #1;
        tv = sample_data_i;
        k = 0;
        do begin
          @(posedge core_clk_i);
          k++;
        end while (recording_indicator_o !== 1'b1 && k < 50);
        `CHECK(test_display_o, TRG_T[i] == 3 && src == 3)
        if (src >= 4) begin
          `CHECK(reset_out_o, 1'b0)
          `CHECK(block_out_o, inm == 2)
          `CHECK(param_set2_o, inm == 3)
        end
        set_src(1'b0);
        n = 0;
        while (recording_indicator_o === 1'b1 && n < 2000) begin
          @(posedge core_clk_i);
          n++;
        end
        `CHECK(n, ((REC_PERIODS * SPP) >> code) - p)
        repeat (3) @(posedge core_clk_i);
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        `CHECK(q[1:0], 2'h3)
        `CHECK(irq_o, i != 4)
        bus(1'b1, OFS_IRQ_CLEAR, 32'h3);
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        `CHECK(q[1:0], 2'h0)
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHECK(q[8:5], 4'((r + 1 < slots - 1) ? r + 1 : slots - 1))
        `CHECK(q[4:2], 3'((r + 1) % slots))
        bus(1'b0, OFS_LAST_START, 32'h0);
        bus(1'b1, OFS_MEM_ADDR, q);
        bus(1'b0, OFS_MEM_DATA, 32'h0);
        `CHECK(q[15:0], 16'(tv - p + 1))
      end
      $display("test case %0d done", i);
    end
    wrap_up();
  end

  initial begin
    #(25 * 60000);
    bad_count++;
    wrap_up();
  end
endmodule : tb
